// ---- sim/pac_master_model.sv ----
// Bus master model that sends request frames and break fields
`timescale 1ns/10ps
module pac_master_model (
    input  wire logic       clk,
    output pac_pkg::pac_rx_t rx,
    output logic            breakActive
);
    import pac_pkg::*;
    // ==========
    // Frame tasks
    initial begin
        rx = '0;
        breakActive = 1'b0;
    end
    // Header pulse, eight bytes with node address first, then end flag
    task automatic send(input logic [5:0] id, input logic [63:0] b, input logic ok);
        @(negedge clk);
        rx.frameStart = 1'b1;
        rx.frameId = id;
        for (int i = 0; i < 8; i++) begin
            @(negedge clk);
            rx.frameStart = 1'b0;
            rx.byteValid = 1'b1;
            rx.byteIdx = 3'(i);
            rx.byteData = b[63 - 8 * i -: 8];
        end
        @(negedge clk);
        rx.byteValid = 1'b0;
        rx.byteData = ~rx.byteData; // Stale byte is not left on the bus
        rx.frameEnd = 1'b1;
        rx.frameOk = ok;
        @(negedge clk);
        rx.frameEnd = 1'b0;
    endtask
    // Break field level
    task automatic bk(input logic v);
        @(negedge clk);
        breakActive = v;
    endtask
endmodule

// ---- sim/pac_position_addressing_asserts.sv ----
// Port checks for the position addressing top
`timescale 1ns/10ps
module pac_position_addressing_asserts (
    input wire logic       clk,
    input wire logic       srst,
    input wire logic       breakActive,
    input wire logic       measStart,
    input wire logic       measRun,
    input wire logic [7:0] nodeAddress,
    input wire logic       nodeAddressUpdated,
    input wire logic       nvmWrite,
    input wire logic [7:0] nvmData
);
    // ==========
    // Properties
    default clocking dc @(posedge clk);
    endclocking
    default disable iff (srst);
    a_start_on_break: assert property (measStart |-> $past(breakActive) && !$past(measRun))
        else $error("start off break");
    a_run_by_start: assert property ($rose(measRun) |-> measStart) else $error("run w/o start");
    a_start_single: assert property (measStart |=> !measStart) else $error("start long");
    a_addr_held: assert property (!nodeAddressUpdated |-> $stable(nodeAddress)) else $error("addr moved");
    a_update_after_break: assert property (nodeAddressUpdated |-> $past(measRun) && !$past(breakActive))
        else $error("update early");
    a_run_closes: assert property (measRun && !breakActive |=> !measRun) else $error("run stuck");
    a_store_data: assert property (nvmWrite |-> nvmData == nodeAddress) else $error("store data");
    a_write_single: assert property (nvmWrite |=> !nvmWrite) else $error("write long");
    c_start: cover property (measStart);
    c_update: cover property (nodeAddressUpdated);
    c_write: cover property (nvmWrite);
endmodule
bind pac_position_addressing pac_position_addressing_asserts u_chk (.clk, .srst, .breakActive, .measStart,
    .measRun, .nodeAddress, .nodeAddressUpdated, .nvmWrite, .nvmData);

// ---- sim/pac_position_addressing_tb.sv ----
// Self-checking bench for the position addressing top
`timescale 1ns/10ps
module pac_position_addressing_tb;
    import pac_pkg::*;
    localparam logic [15:0] SUP = 16'hA35C; // Arbitrary value
    logic        clk, srst, breakActive, measSelected, measDone, nvmBusy, measStart, measRun, upd, nvmWrite, sel;
    logic [7:0]  nodeAddress, nvmData, expAddr, na;
    logic [63:0] f;
    pac_rx_t     rx;
    int          err_count, n_compared, starts, upds, writes;
    pac_master_model m (.clk(clk), .rx(rx), .breakActive(breakActive));
    pac_position_addressing #(.SUPPLIER_ID(SUP)) dut (.clk(clk), .srst(srst), .rx(rx), .breakActive(breakActive),
        .measSelected(measSelected), .measDone(measDone), .nvmBusy(nvmBusy), .measStart(measStart),
        .measRun(measRun), .nodeAddress(nodeAddress), .nodeAddressUpdated(upd), .nvmWrite(nvmWrite),
        .nvmData(nvmData));
    // ==========
    // Clock, pulse counters, helpers
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    always @(posedge clk) begin
        starts += int'(measStart === 1'b1);
        upds += int'(upd === 1'b1);
        writes += int'(nvmWrite === 1'b1);
    end
    function automatic logic [63:0] req(input logic [7:0] fn, input logic [7:0] d5);
        return {8'h7F, 8'h06, 8'hB5, SUP[7:0], SUP[15:8], fn, 8'h02, d5};
    endfunction
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        n_compared++;
        if (g !== e) begin
            $display("Error %s expected %h seen %h", nm, e, g);
            err_count++;
        end
    endtask
    task automatic conclude();
        $display("Compared %0d, mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // Break with one measurement result, then compare pulses and address
    task automatic round(input logic s, input logic [7:0] es, input logic [7:0] ea);
        starts = 0;
        upds = 0;
        m.bk(1'b1);
        measSelected = s;
        repeat (3) @(negedge clk);
        chk("measRun in break", {7'h0, es[0]}, {7'h0, measRun});
        measDone = 1'b1;
        @(negedge clk);
        measDone = 1'b0;
        m.bk(1'b0);
        repeat (4) @(negedge clk);
        chk("measRun after break", 8'h00, {7'h0, measRun});
        chk("measStart count", es, 8'(starts));
        chk("update count", es & {7'h0, s}, 8'(upds));
        chk("nodeAddress", ea, nodeAddress);
        measSelected = 1'b0;
        expAddr = ea;
    endtask
    initial begin
        #50000;
        err_count++;
        conclude();
    end
    initial begin
        srst = 1'b1;
        measSelected = 1'b0;
        measDone = 1'b0;
        nvmBusy = 1'b0;
        void'($urandom(32'h71BC17A9));
        repeat (8) @(negedge clk);
        srst = 1'b0;
        round(1'b1, 8'h00, 8'h7F);
        // Random assigns, foreign frames interleaved, selected or not
        for (int r = 0; r < 6; r++) begin
            na = 8'($urandom);
            sel = 1'($urandom);
            m.send(6'h3C, req(8'h02, na), 1'b1);
            repeat (r % 3) m.send(6'($urandom % 60), {$urandom, $urandom}, 1'b1);
            round(sel, 8'h01, sel ? na : expAddr);
        end
        // One bad byte, bad id or bad checksum per frame
        for (int k = 0; k < 9; k++) begin
            f = req(8'h02, 8'h11);
            if (k < 7)
                f[63 - 8 * k -: 8] = ~f[63 - 8 * k -: 8];
            m.send(k == 7 ? 6'h3D : 6'h3C, f, k != 8);
            round(1'b1, 8'h00, expAddr);
        end
        // Store: bad filler first, then a good one held off by busy
        writes = 0;
        m.send(6'h3C, req(8'h03, 8'h00), 1'b1);
        repeat (3) @(negedge clk);
        chk("write on bad filler", 8'h00, 8'(writes));
        nvmBusy = 1'b1;
        m.send(6'h3C, req(8'h03, 8'hFF), 1'b1);
        repeat (6) @(negedge clk);
        chk("write while busy", 8'h00, 8'(writes));
        nvmBusy = 1'b0;
        for (int w = 0; w < 10 && writes == 0; w++)
            @(negedge clk);
        chk("write count", 8'h01, 8'(writes));
        chk("nvmData", expAddr, nvmData);
        // Reset while idle after the store returns the address to its reset value, then addressing works again
        srst = 1'b1;
        repeat (2) @(negedge clk);
        srst = 1'b0;
        @(negedge clk);
        chk("nodeAddress after reset", 8'h7F, nodeAddress);
        m.send(6'h3C, req(8'h02, 8'h2A), 1'b1);
        round(1'b1, 8'h01, 8'h2A);
        conclude();
    end
endmodule

// ---- src/pac_frame_decoder.sv ----
// Byte checker that decodes one addressing request frame
`timescale 1ns/10ps
`include "pac_regs.svh"
module pac_frame_decoder #(
    parameter logic [15:0] SUPPLIER_ID = 16'h7FFF
) (
    input  wire logic          clk,
    input  wire logic          srst,
    input  wire pac_pkg::pac_rx_t rx,
    output logic               cmdValid,
    output pac_pkg::pac_cmd_t  cmdKind,
    output logic [7:0]         cmdNad
);
    import pac_pkg::*;

    logic       inFrame_ff;
    logic       match_ff;
    logic       isAssign_ff;
    logic       isStore_ff;
    logic [7:0] newNad_ff;
    logic       byteOk;

    // ============================================================
    // Per-byte comparison against expected request layout
    always_comb begin
        byteOk = 1'b1;
        case (rx.byteIdx)
            `PAC_IDX_NAD: byteOk = (rx.byteData == `PAC_BCAST_NAD);
            `PAC_IDX_PCI: byteOk = (rx.byteData == `PAC_PCI);
            `PAC_IDX_SID: byteOk = (rx.byteData == `PAC_SID);
            `PAC_IDX_D1:  byteOk = (rx.byteData == SUPPLIER_ID[7:0]);
            `PAC_IDX_D2:  byteOk = (rx.byteData == SUPPLIER_ID[15:8]);
            `PAC_IDX_D3:  byteOk = (rx.byteData == `PAC_FN_ASSIGN) || (rx.byteData == `PAC_FN_STORE);
            `PAC_IDX_D4:  byteOk = (rx.byteData == `PAC_FN_MSB);
            `PAC_IDX_D5:  byteOk = isAssign_ff || (rx.byteData == `PAC_D5_UNUSED);
            default:      byteOk = 1'b0;
        endcase
    end

    // ============================================================
    // Frame tracking; other identifiers are passed over untouched
    always_ff @(posedge clk) begin
        if (srst) begin
            inFrame_ff  <= 1'b0;
            match_ff    <= 1'b0;
            isAssign_ff <= 1'b0;
            isStore_ff  <= 1'b0;
            newNad_ff   <= 8'h00;
        end else if (rx.frameStart) begin
            inFrame_ff  <= (rx.frameId == `PAC_FRAME_ID);
            match_ff    <= 1'b1;
            isAssign_ff <= 1'b0;
            isStore_ff  <= 1'b0;
        end else if (inFrame_ff && rx.byteValid) begin
            match_ff <= match_ff && byteOk;
            if (rx.byteIdx == `PAC_IDX_D3) begin
                isAssign_ff <= (rx.byteData == `PAC_FN_ASSIGN);
                isStore_ff  <= (rx.byteData == `PAC_FN_STORE);
            end
            if (rx.byteIdx == `PAC_IDX_D5) begin
                newNad_ff <= rx.byteData;
            end
        end else if (rx.frameEnd) begin
            inFrame_ff <= 1'b0;
        end
    end

    // ============================================================
    // Command pulse at end of a good, fully matching frame
    always_ff @(posedge clk) begin
        if (srst) begin
            cmdValid <= 1'b0;
            cmdKind  <= PAC_CMD_NONE;
            cmdNad   <= 8'h00;
        end else begin
            cmdValid <= 1'b0;
            if (rx.frameEnd && inFrame_ff && rx.frameOk && match_ff) begin
                cmdValid <= isAssign_ff || isStore_ff;
                cmdKind  <= isAssign_ff ? PAC_CMD_ASSIGN :
                            (isStore_ff ? PAC_CMD_STORE : PAC_CMD_NONE);
                cmdNad   <= newNad_ff;
            end
        end
    end
endmodule

// ---- src/pac_pkg.sv ----
// Types for the position addressing command interpreter
package pac_pkg;
    // One received frame byte with its position
    typedef struct packed {
        logic       frameStart;
        logic [5:0] frameId;
        logic       byteValid;
        logic [2:0] byteIdx;
        logic [7:0] byteData;
        logic       frameEnd;
        logic       frameOk;
    } pac_rx_t;

    // Decoded command
    typedef enum logic [1:0] {
        PAC_CMD_NONE   = 2'h0,
        PAC_CMD_ASSIGN = 2'h1,
        PAC_CMD_STORE  = 2'h2
    } pac_cmd_t;

    // Addressing state, one-hot
    typedef enum logic [2:0] {
        PAC_ST_IDLE    = 3'b001,
        PAC_ST_ARMED   = 3'b010,
        PAC_ST_MEASURE = 3'b100
    } pac_state_t;
endpackage

// ---- src/pac_position_addressing.sv ----
// Top of the position addressing command interpreter
`timescale 1ns/10ps
`include "pac_regs.svh"
module pac_position_addressing #(
    parameter logic [15:0] SUPPLIER_ID = 16'h7FFF, // Arbitrary value
    parameter logic        HAS_NVM     = 1'b1
) (
    input  wire logic             clk,
    input  wire logic             srst,
    input  wire pac_pkg::pac_rx_t rx,
    input  wire logic             breakActive,
    input  wire logic             measSelected,
    input  wire logic             measDone,
    input  wire logic             nvmBusy,
    output logic                  measStart,
    output logic                  measRun,
    output logic [7:0]            nodeAddress,
    output logic                  nodeAddressUpdated,
    output logic                  nvmWrite,
    output logic [7:0]            nvmData
);
    import pac_pkg::*;

    logic       cmdValid;
    pac_cmd_t   cmdKind;
    logic [7:0] cmdNad;
    pac_state_t state_ff;
    pac_state_t nxt_state;
    logic [7:0] pendNad_ff;
    logic       breakSeen_ff;
    logic       selLatch_ff;
    logic       storePend_ff;

    // ============================================================
    // Request decoding
    pac_frame_decoder #(
        .SUPPLIER_ID (SUPPLIER_ID)
    ) u_dec (
        .clk      (clk),
        .srst     (srst),
        .rx       (rx),
        .cmdValid (cmdValid),
        .cmdKind  (cmdKind),
        .cmdNad   (cmdNad)
    );

    // ============================================================
    // Addressing sequence: armed waits for the next break
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            PAC_ST_IDLE: begin
                if (cmdValid && cmdKind == PAC_CMD_ASSIGN) begin
                    nxt_state = PAC_ST_ARMED;
                end
            end
            PAC_ST_ARMED: begin
                if (breakActive) begin
                    nxt_state = PAC_ST_MEASURE;
                end
            end
            PAC_ST_MEASURE: begin
                if (!breakActive) begin
                    nxt_state = PAC_ST_IDLE;
                end
            end
            default: nxt_state = PAC_ST_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            state_ff <= PAC_ST_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // Pending address kept until the break has ended
    always_ff @(posedge clk) begin
        if (srst) begin
            pendNad_ff <= 8'h00;
        end else if (state_ff == PAC_ST_IDLE && cmdValid && cmdKind == PAC_CMD_ASSIGN) begin
            pendNad_ff <= cmdNad;
        end
    end

    // ============================================================
    // Measurement control toward the shunt front end
    always_ff @(posedge clk) begin
        if (srst) begin
            measStart    <= 1'b0;
            measRun      <= 1'b0;
            breakSeen_ff <= 1'b0;
            selLatch_ff  <= 1'b0;
        end else begin
            measStart    <= (state_ff == PAC_ST_ARMED) && breakActive;
            measRun      <= (nxt_state == PAC_ST_MEASURE);
            breakSeen_ff <= (state_ff == PAC_ST_MEASURE);
            if (state_ff == PAC_ST_ARMED) begin
                selLatch_ff <= 1'b0;
            end else if (state_ff == PAC_ST_MEASURE && measDone) begin
                selLatch_ff <= measSelected;                  // Selection result
            end
        end
    end

    // ============================================================
    // Node address adoption after the break
    always_ff @(posedge clk) begin
        if (srst) begin
            nodeAddress        <= `PAC_NAD_RESET;
            nodeAddressUpdated <= 1'b0;
        end else begin
            nodeAddressUpdated <= 1'b0;
            if (state_ff == PAC_ST_MEASURE && !breakActive && selLatch_ff) begin
                nodeAddress        <= pendNad_ff;
                nodeAddressUpdated <= 1'b1;
            end
        end
    end

    // ============================================================
    // Copy to non-volatile memory on a store request
    always_ff @(posedge clk) begin
        if (srst) begin
            storePend_ff <= 1'b0;
            nvmWrite     <= 1'b0;
            nvmData      <= 8'h00;
        end else begin
            nvmWrite <= 1'b0;
            if (cmdValid && cmdKind == PAC_CMD_STORE && HAS_NVM) begin
                storePend_ff <= 1'b1;
            end else if (storePend_ff && !nvmBusy) begin
                storePend_ff <= 1'b0;
                nvmWrite     <= 1'b1;
                nvmData      <= nodeAddress;
            end
        end
    end
endmodule

// ---- src/pac_regs.svh ----
// Constants for the position addressing command interpreter
// Operation
// - Addressing requests come in the master request frame 0x3C with node address 0x7F, protocol control 0x06 and service 0xB5.
// - Assign request carries supplier identity in D1/D2, function 0x02/0x02 in D3/D4 and the new node address in D5.
// - On an assign request every capable slave runs its position measurement in the following break field.
// - After that break only the slave chosen by the measurement adopts the new node address; others keep theirs.
// - Store request has the same header and service bytes with D3 0x03, D4 0x02 and D5 unused at 0xFF.
// - On a store request every capable slave copies its assigned node address into non-volatile memory if present.
`ifndef PAC_REGS_SVH
`define PAC_REGS_SVH
`define PAC_FRAME_ID      6'h3C
`define PAC_BCAST_NAD     8'h7F
`define PAC_PCI           8'h06
`define PAC_SID           8'hB5
`define PAC_FN_ASSIGN     8'h02
`define PAC_FN_STORE      8'h03
`define PAC_FN_MSB        8'h02
`define PAC_D5_UNUSED     8'hFF
`define PAC_NAD_RESET     8'h7F
`define PAC_BYTE_IDX_W    3
`define PAC_LAST_BYTE     3'h7
`define PAC_IDX_NAD       3'h0
`define PAC_IDX_PCI       3'h1
`define PAC_IDX_SID       3'h2
`define PAC_IDX_D1        3'h3
`define PAC_IDX_D2        3'h4
`define PAC_IDX_D3        3'h5
`define PAC_IDX_D4        3'h6
`define PAC_IDX_D5        3'h7
`endif
